// ===== vidpi_pkg.sv
// Package for the parallel voltage code input, both ends.
// Assumes one 20 MHz system clock at each end and a shared pin bundle.
package vidpi_pkg;
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned POLL_US       = 400;
    localparam int unsigned CALC_MIN_US   = 35;
    localparam int unsigned HOLD_MIN_US   = 70;
    localparam int unsigned PHASE_US      = 125;
    localparam int unsigned POLL_CYC      = POLL_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CALC_CYC      = CALC_MIN_US * (CLK_HZ / 1_000_000);
    localparam int unsigned PHASE_CYC     = PHASE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CODE_W        = 6;
    // One confirming poll puts acceptance 400-800 us after a code change
    localparam int unsigned STABLE_POLLS  = 1;
    localparam logic [3:0]  LINES_IDLE    = 4'h8;
    localparam logic [7:0]  SLEW_DEFAULT  = 8'h10;
    localparam logic [5:0]  CODE_MAX      = 6'h3F;
    localparam logic [5:0]  CODE_MIN      = 6'h00;
    typedef enum logic [1:0] {VIDPI_MODE_4BIT, VIDPI_MODE_6BIT,
                              VIDPI_MODE_SERIAL} vidpi_mode_e;
endpackage

// ===== vidpi_if.sv
// Pin bundle between host code driver and controller code input.
// Assumes host drives all four lines; device only reads them.
`timescale 1ns/1ps
interface vidpi_if;
    logic voltage_code_line_a;
    logic voltage_code_line_b;
    logic voltage_code_line_c;
    logic voltage_code_select;
    modport host   (output voltage_code_line_a, voltage_code_line_b,
                    voltage_code_line_c, voltage_code_select);
    modport device (input  voltage_code_line_a, voltage_code_line_b,
                    voltage_code_line_c, voltage_code_select);
endinterface

// ===== vidpi_device.sv
// Controller end: turns the four code lines into a slewing setpoint.
// Assumes lines are asynchronous to clock; config held steady by user.
`timescale 1ns/1ps
module vidpi_device
    import vidpi_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                sys_rst,
    vidpi_if.device                  pins,
    input  wire vidpi_mode_e         voltage_code_config_cmd,
    input  wire logic [CODE_W-1:0]   cfg_upper_code,
    input  wire logic [CODE_W-1:0]   cfg_lower_code,
    input  wire logic [CODE_W-1:0]   cfg_start_code,
    input  wire logic [7:0]          output_slew_rate_setting,
    output logic [CODE_W-1:0]        voltage_id_code,
    output logic [CODE_W-1:0]        setpoint_target,
    output logic [CODE_W-1:0]        setpoint_now,
    output logic                     setpoint_slewing
);
    function automatic logic [CODE_W-1:0] clamp_code
        (input logic [CODE_W-1:0] c, input logic [CODE_W-1:0] lo,
         input logic [CODE_W-1:0] hi);
        if (c > hi)
            return hi;
        else if (c < lo)
            return lo;
        else
            return c;
    endfunction

    logic [3:0] meta_q, sync_q, prev_q;
    always_ff @(posedge clock)
    begin
        meta_q <= {pins.voltage_code_select, pins.voltage_code_line_c,
                   pins.voltage_code_line_b, pins.voltage_code_line_a};
        sync_q <= meta_q;
        prev_q <= sync_q;
    end

    wire sel_fall = prev_q[3] & ~sync_q[3];
    wire sel_rise = ~prev_q[3] & sync_q[3];

    logic [18:0]       poll_cnt_q, poll_cnt_d;
    logic [3:0]        last_poll_q, last_poll_d;
    logic [1:0]        same_q, same_d;
    logic [2:0]        low_bits_q, low_bits_d;
    logic [11:0]       calc_cnt_q, calc_cnt_d;
    logic              calc_busy_q, calc_busy_d;
    logic [CODE_W-1:0] raw_q, raw_d;
    logic [CODE_W-1:0] code_q, code_d, tgt_q, tgt_d, now_q, now_d;
    logic [7:0]        slew_cnt_q, slew_cnt_d;
    logic              started_q, started_d;
    logic              slewing_q, slewing_d;

    always_comb
    begin
        poll_cnt_d  = poll_cnt_q;
        last_poll_d = last_poll_q;
        same_d      = same_q;
        low_bits_d  = low_bits_q;
        calc_cnt_d  = calc_cnt_q;
        calc_busy_d = calc_busy_q;
        raw_d       = raw_q;
        code_d      = code_q;
        tgt_d       = tgt_q;
        now_d       = now_q;
        slew_cnt_d  = slew_cnt_q;
        started_d   = 1'b1;
        slewing_d   = (now_q != tgt_q);
        if (!started_q)
        begin
            code_d = clamp_code(cfg_start_code, cfg_lower_code,
                                cfg_upper_code);
            tgt_d  = code_d;
            now_d  = code_d;
        end
        else
        begin
            unique case (voltage_code_config_cmd)
                VIDPI_MODE_4BIT:
                begin
                    if (poll_cnt_q == 19'(POLL_CYC - 1))
                    begin
                        poll_cnt_d  = '0;
                        last_poll_d = sync_q;
                        if (sync_q != last_poll_q)
                            same_d = '0;
                        else if (same_q != 2'(STABLE_POLLS))
                        begin
                            same_d = same_q + 2'h1;
                            if (same_q == 2'(STABLE_POLLS - 1))
                            begin
                                code_d = {2'h0, sync_q};
                                tgt_d  = clamp_code({2'h0, sync_q},
                                         cfg_lower_code,
                                         cfg_upper_code);
                            end
                        end
                    end
                    else
                        poll_cnt_d = poll_cnt_q + 19'h1;
                end
                VIDPI_MODE_6BIT:
                begin
                    if (sel_fall)
                        low_bits_d = sync_q[2:0];
                    if (sel_rise)
                    begin
                        raw_d       = {sync_q[2:0], low_bits_q};
                        calc_busy_d = 1'b1;
                        calc_cnt_d  = '0;
                    end
                    else if (calc_busy_q)
                    begin
                        calc_cnt_d = calc_cnt_q + 12'h1;
                        if (calc_cnt_q == 12'(CALC_CYC - 1))
                        begin
                            calc_busy_d = 1'b0;
                            code_d      = raw_q;
                            tgt_d       = clamp_code(raw_q, cfg_lower_code,
                                                     cfg_upper_code);
                        end
                    end
                end
                default:
                begin
                    poll_cnt_d = '0;
                end
            endcase
            // One step per slew period so the output ramps
            if (now_q != tgt_q)
            begin
                if (slew_cnt_q >= output_slew_rate_setting)
                begin
                    slew_cnt_d = '0;
                    now_d = (now_q < tgt_q) ? now_q + 6'h1
                                            : now_q - 6'h1;
                end
                else
                    slew_cnt_d = slew_cnt_q + 8'h1;
            end
            else
                slew_cnt_d = '0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            poll_cnt_q  <= '0;
            last_poll_q <= '0;
            same_q      <= '0;
            low_bits_q  <= '0;
            calc_cnt_q  <= '0;
            calc_busy_q <= 1'b0;
            raw_q       <= '0;
            code_q      <= '0;
            tgt_q       <= '0;
            now_q       <= '0;
            slew_cnt_q  <= '0;
            started_q   <= 1'b0;
            slewing_q   <= 1'b0;
        end
        else
        begin
            poll_cnt_q  <= poll_cnt_d;
            last_poll_q <= last_poll_d;
            same_q      <= same_d;
            low_bits_q  <= low_bits_d;
            calc_cnt_q  <= calc_cnt_d;
            calc_busy_q <= calc_busy_d;
            raw_q       <= raw_d;
            code_q      <= code_d;
            tgt_q       <= tgt_d;
            now_q       <= now_d;
            slew_cnt_q  <= slew_cnt_d;
            started_q   <= started_d;
            slewing_q   <= slewing_d;
        end
    end

    assign voltage_id_code  = code_q;
    assign setpoint_target  = tgt_q;
    assign setpoint_now     = now_q;
    assign setpoint_slewing = slewing_q;
endmodule // vidpi_device

// ===== vidpi_host.sv
// Host end: presents a code on the four lines, 4-bit or 6-bit mode.
// Assumes the user raises send only when the voltage must change.
`timescale 1ns/1ps
module vidpi_host
    import vidpi_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                sys_rst,
    vidpi_if.host                    pins,
    input  wire logic                mode_6bit,
    input  wire logic                send,
    input  wire logic [CODE_W-1:0]   send_code,
    output logic                     busy
);
    typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} vidpi_hst_e;
    vidpi_hst_e        st_q, st_d;
    logic [3:0]        lines_q, lines_d;
    logic [12:0]       cnt_q, cnt_d;
    logic [CODE_W-1:0] code_q, code_d;
    logic              busy_q, busy_d;

    always_comb
    begin
        st_d    = st_q;
        lines_d = lines_q;
        cnt_d   = cnt_q;
        code_d  = code_q;
        unique case (st_q)
            H_IDLE:
            begin
                if (send)
                begin
                    code_d = send_code;
                    cnt_d  = '0;
                    if (mode_6bit)
                    begin
                        lines_d = {1'b0, send_code[2:0]};
                        st_d    = H_LOW;
                    end
                    else
                    begin
                        lines_d = send_code[3:0];
                        st_d    = H_HIGH;
                    end
                end
            end
            H_LOW:
            begin
                cnt_d = cnt_q + 13'h1;
                if (cnt_q == 13'(PHASE_CYC - 1))
                begin
                    lines_d = {1'b1, code_q[5:3]};
                    cnt_d   = '0;
                    st_d    = H_HIGH;
                end
            end
            H_HIGH:
            begin
                cnt_d = cnt_q + 13'h1;
                if (cnt_q == 13'(PHASE_CYC - 1))
                    st_d = H_IDLE;
            end
            default:
                st_d = H_IDLE;
        endcase
        busy_d = (st_d != H_IDLE);
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            st_q    <= H_IDLE;
            lines_q <= LINES_IDLE;
            cnt_q   <= '0;
            code_q  <= '0;
            busy_q  <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            lines_q <= lines_d;
            cnt_q   <= cnt_d;
            code_q  <= code_d;
            busy_q  <= busy_d;
        end
    end

    assign pins.voltage_code_line_a = lines_q[0];
    assign pins.voltage_code_line_b = lines_q[1];
    assign pins.voltage_code_line_c = lines_q[2];
    assign pins.voltage_code_select = lines_q[3];
    assign busy = busy_q;
endmodule // vidpi_host

// ===== vidpi_chk.sv
// Checker of the four voltage code lines between host and device ends.
// Assumes one clock domain; instantiated beside the pin bundle.
`timescale 1ns/1ps
module vidpi_chk
    import vidpi_pkg::*;
(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic voltage_code_line_a,
    input  wire logic voltage_code_line_b,
    input  wire logic voltage_code_line_c,
    input  wire logic voltage_code_select,
    input  wire logic mode_6bit
);
    logic [3:0]  lines;
    logic [3:0]  prev_q;
    logic [3:0]  prev_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [11:0] low_q;
    logic [11:0] low_d;
    localparam int unsigned HOLD_CYC = HOLD_MIN_US * (CLK_HZ / 1_000_000);
    // Counted, not a delay range: the low phase is too long to unroll
    localparam int unsigned LOW_MAX  = PHASE_CYC + 100;
    assign lines = {voltage_code_select, voltage_code_line_c,
                    voltage_code_line_b, voltage_code_line_a};
    // Reset saturates the count so a first send is never flagged
    always_comb
    begin
        prev_d = lines;
        cnt_d  = (cnt_q == 16'hFFFF) ? cnt_q : cnt_q + 16'h0001;
        low_d  = low_q;
        if (sys_rst || voltage_code_select)
            low_d = 12'h000;
        else if (low_q != 12'hFFF)
            low_d = low_q + 12'h001;
        if (sys_rst)
            cnt_d = 16'hFFFF;
        else if (lines != prev_q)
            cnt_d = 16'h0000;
    end
    always_ff @(posedge clock)
    begin
        prev_q <= prev_d;
        cnt_q  <= cnt_d;
        low_q  <= low_d;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_fall6;
        mode_6bit && $fell(voltage_code_select);
    endsequence
    sequence s_rise6;
        mode_6bit && $rose(voltage_code_select);
    endsequence
    sequence s_hold8;
        $stable(lines) [*8];
    endsequence
    property p_reset_idle;
        @(posedge clock) disable iff (1'b0)
        $fell(sys_rst) |-> (lines == LINES_IDLE);
    endproperty
    property p_hold_min;
        (lines != prev_q) |-> (cnt_q >= 16'(HOLD_CYC - 1));
    endproperty
    property p_low_phase;
        s_rise6 |-> (cnt_q >= 16'(PHASE_CYC - 1));
    endproperty
    property p_high_phase;
        s_fall6 |-> (cnt_q >= 16'(PHASE_CYC - 1));
    endproperty
    property p_data_with_sel;
        mode_6bit && (lines[2:0] != prev_q[2:0]) |-> lines[3] != prev_q[3];
    endproperty
    property p_rise_follows;
        (mode_6bit && !voltage_code_select) |-> (low_q < 12'(LOW_MAX));
    endproperty
    property p_hold_fall;
        s_fall6 |=> s_hold8;
    endproperty
    property p_hold_rise;
        s_rise6 |=> s_hold8;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("code lines not idle after reset");
    a_hold_min: assert property (p_hold_min)
        else $error("code lines changed too soon");
    a_low_phase: assert property (p_low_phase)
        else $error("select low phase too short");
    a_high_phase: assert property (p_high_phase)
        else $error("select high phase too short");
    a_data_with_sel: assert property (p_data_with_sel)
        else $error("data changed without select edge");
    a_rise_follows: assert property (p_rise_follows)
        else $error("no select rise after fall");
    a_hold_fall: assert property (p_hold_fall)
        else $error("lines moved after select fall");
    a_hold_rise: assert property (p_hold_rise)
        else $error("lines moved after select rise");
endmodule // vidpi_chk

// ===== tb_top.sv
// Testbench joining host and device ends over the pin bundle.
// Assumes 20 MHz clock; long waits follow the polling period.
`timescale 1ns/1ps
module tb_top
    import vidpi_pkg::*;
;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    vidpi_mode_e cfg_mode = VIDPI_MODE_4BIT;
    logic        mode_6bit = 1'b0;
    logic        send = 1'b0;
    logic [5:0]  host_code = 6'h00;
    logic        busy;
    logic [5:0]  id_code;
    logic [5:0]  target;
    logic [5:0]  now_sp;
    logic        slewing;
    int          miscompares = 0;
    int          check_count = 0;
    int          n;
    vidpi_if pins_if();
    vidpi_device i_vidpi_device (.clock(clock), .sys_rst(sys_rst),
        .pins(pins_if.device), .voltage_code_config_cmd(cfg_mode),
        .cfg_upper_code(6'h30), .cfg_lower_code(6'h04),
        .cfg_start_code(6'h02), .output_slew_rate_setting(8'h03),
        .voltage_id_code(id_code), .setpoint_target(target),
        .setpoint_now(now_sp), .setpoint_slewing(slewing));
    vidpi_host i_vidpi_host (.clock(clock), .sys_rst(sys_rst),
        .pins(pins_if.host), .mode_6bit(mode_6bit), .send(send),
        .send_code(host_code), .busy(busy));
    vidpi_chk i_vidpi_chk (.clock(clock), .sys_rst(sys_rst),
        .voltage_code_line_a(pins_if.voltage_code_line_a),
        .voltage_code_line_b(pins_if.voltage_code_line_b),
        .voltage_code_line_c(pins_if.voltage_code_line_c),
        .voltage_code_select(pins_if.voltage_code_select),
        .mode_6bit(mode_6bit));
    always #25 clock = ~clock;
    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
            miscompares++;
        end
    endtask
    task automatic launch(input logic [5:0] code);
        @(negedge clock);
        send = 1'b1;
        host_code = code;
        @(negedge clock);
        send = 1'b0;
    endtask
    // Bounded waits: a stuck end shows as a mismatch, not a hang
    task automatic wait_sel(input logic level);
        n = 0;
        while (pins_if.voltage_code_select !== level && n < 6000)
        begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic wait_target(input logic [5:0] code);
        n = 0;
        while (target !== code && n < 30000)
        begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic wait_idle();
        repeat (6000)
            if (busy !== 1'b0)
                @(negedge clock);
        check("host_idle", 8'h00, {7'h0, busy});
    endtask
    task automatic t_reset();
        check("start_target", 8'h04, {2'b0, target});
        check("start_now", 8'h04, {2'b0, now_sp});
    endtask
    task automatic t_four_bit();
        launch(6'h0A);
        wait_target(6'h0A);
        check("poll_min", 8'h01, {7'h0, n >= POLL_CYC});
        check("poll_max", 8'h01, {7'h0, n <= 2 * POLL_CYC + 20});
        check("code4", 8'h0A, {2'b0, id_code});
        check("no_step", 8'h01, {7'h0, now_sp !== 6'h0A});
        @(negedge clock);
        check("slewing", 8'h01, {7'h0, slewing});
        repeat (200)
            @(negedge clock);
        check("slew_end", 8'h0A, {2'b0, now_sp});
        check("slew_flag", 8'h00, {7'h0, slewing});
        wait_idle();
    endtask
    task automatic t_six_bit(input logic [5:0] code, input logic [5:0] exp);
        logic [5:0] old;
        old = target;
        cfg_mode = VIDPI_MODE_6BIT;
        mode_6bit = 1'b1;
        launch(code);
        wait_sel(1'b0);
        repeat (100)
            @(negedge clock);
        check("before_rise", {2'b0, old}, {2'b0, target});
        wait_sel(1'b1);
        wait_target(exp);
        check("calc_min", 8'h01, {7'h0, n >= 690});
        check("calc_max", 8'h01, {7'h0, n <= 2700});
        check("code6", {2'b0, code}, {2'b0, id_code});
        wait_idle();
    endtask
    // Serial mode must leave the setpoint where it was
    task automatic t_serial();
        cfg_mode = VIDPI_MODE_SERIAL;
        launch(6'h10);
        wait_idle();
        repeat (1000)
            @(negedge clock);
        check("serial_hold", 8'h30, {2'b0, target});
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4)
            @(negedge clock);
        sys_rst = 1'b0;
        repeat (3)
            @(negedge clock);
        t_reset();
        t_four_bit();
        t_six_bit(6'h2D, 6'h2D);
        t_six_bit(6'h3F, 6'h30);
        t_serial();
        report_and_stop();
    end
    initial
    begin
        #4_000_000;
        miscompares++;
        report_and_stop();
    end
endmodule // tb_top
